// ---- bench/dac_model.sv ----
`timescale 1ns/1ps
// ****************************************
// converter pair: rebuilds each serial word from the msb-first pins
// ****************************************
module dac_model
    import nco_out_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic [nco_out_pkg::AMP_W-1:0] sine_out,
    input  wire logic [nco_out_pkg::AMP_W-1:0] cosine_out,
    input  wire logic                          converter_word_strobe,
    output logic      [nco_out_pkg::AMP_W-1:0] sine_word,
    output logic      [nco_out_pkg::AMP_W-1:0] cosine_word
);
    logic [AMP_W-1:0] sin_sh_q;      // sine bits gathered so far
    logic [AMP_W-1:0] cos_sh_q;      // cosine bits gathered so far
    logic [4:0]       cnt_q = '0;    // bits still to come

    // the strobe marks the first bit; fifteen more follow, msb first
    always_ff @(posedge clk)
    begin
        if (converter_word_strobe)
        begin
            sin_sh_q <= AMP_W'(sine_out[15]);
            cos_sh_q <= AMP_W'(cosine_out[15]);
            cnt_q    <= 5'd15;
        end
        else if (cnt_q != 5'd0)
        begin
            sin_sh_q <= {sin_sh_q[14:0], sine_out[15]};
            cos_sh_q <= {cos_sh_q[14:0], cosine_out[15]};
            cnt_q    <= cnt_q - 5'd1;
        end
    end

    // no word framing check here: a late strobe simply restarts the word
    assign sine_word   = sin_sh_q;
    assign cosine_word = cos_sh_q;
endmodule // dac_model

// ---- bench/test_quad_amp_out.sv ----
`timescale 1ns/1ps
module test_quad_amp_out;
    import nco_out_pkg::*;

    // ****************************************
    // design inputs, outputs and bench state
    // ****************************************
    logic               clk = 0;                 // 200 MHz
    logic               sys_rst = 1;             // synchronous, high
    logic [PHASE_W-1:0] phase_word = '0;
    logic               phase_valid = 0;
    logic               phase_ready;
    logic               phase_accum_enable = 0;  // load when high in serial mode
    logic [AMP_W-1:0]   sine_out, cosine_out, sine_word, cosine_word;
    logic               converter_word_strobe;
    logic [3:0]         s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
    logic [31:0]        s_axi_wdata = '0, s_axi_rdata;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic               s_axi_arvalid = 0, s_axi_rready = 0;
    logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int                 miscompares = 0;
    int                 comparisons = 0;
    int                 seed = 32'h3c6f_da7b;
    int                 amp [4] = '{0, 32767, 0, -32767}; // sine at quarter turns
    logic [PHASE_W-1:0] q [$];                   // words sent to the buffer
    logic [PHASE_W-1:0] p;
    logic [AMP_W-1:0]   c1;
    logic [31:0]        rd;
    logic [1:0]         rsp;

    quad_amp_out dut (.*);
    dac_model    dac (.*);

    always #2.5 clk = ~clk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // low select means offset binary: only the msb flips
    function automatic logic [15:0] fmt(input int v, input logic obin_n);
        return 16'(v) ^ (obin_n ? 16'h0000 : 16'h8000);
    endfunction

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 0;
        w_done  = 0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        // each channel is released at its own accepting edge
        while (!(aw_done && w_done))
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // offer one word; valid stays up so pushes can run back to back
    task automatic push(input logic [PHASE_W-1:0] w);
        phase_word  <= w;
        phase_valid <= 1'b1;
        do @(posedge clk); while (!phase_ready);
    endtask

    // one word through the parallel path, sampled once settled
    task automatic apply(input logic [PHASE_W-1:0] w);
        @(posedge clk);
        push(w);
        phase_valid <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************
    // watchdog: the whole run needs a few hundred cycles
    // ****************************************
    initial
    begin
        #100_000;
        miscompares++;
        end_of_test;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        axi_rd(CTRL_OFS, rd, rsp);
        check(rd, 32'h0000_0001, "ctrl after reset");
        axi_rd(STATUS_OFS, rd, rsp);
        check(rd, 32'h0000_0001, "status after reset");
        axi_rd(4'hc, rd, rsp);
        check(rsp, RESP_SLVERR, "unmapped read resp");
        check(rd, 32'h0000_0000, "unmapped read data");
        axi_wr(STATUS_OFS, 32'h0000_0000, rsp);
        check(rsp, RESP_SLVERR, "read-only write");
        $display("test registers done");
        // quarter turns in both formats; expected from exact peaks
        for (int f = 1; f >= 0; f--)
        begin
            axi_wr(CTRL_OFS, 32'(f), rsp);
            for (int k = 0; k < 4; k++)
            begin
                apply({k[1:0], 26'h000_0000});
                check(sine_out, fmt(amp[k], f[0]), "sine quarter");
                check(cosine_out, fmt(amp[(k + 1) % 4], f[0]), "cosine quarter");
            end
        end
        // snapshot still holds the last quarter turn in offset binary
        axi_rd(SAMPLE_OFS, rd, rsp);
        check(rd, {fmt(amp[0], 1'b0), fmt(amp[3], 1'b0)}, "sample word");
        // random phases: cosine equals sine a quarter on, low bits ignored
        axi_wr(CTRL_OFS, 32'h0000_0001, rsp);
        repeat (20)
        begin
            p = 28'($random(seed));
            apply(p);
            c1 = cosine_out;
            check(32'(sine_out !== 16'h8000 && c1 !== 16'h8000), 32'h1, "span");
            p = p + 28'h400_0000;
            p[7:0] = 8'($random(seed));
            apply(p);
            check(sine_out, c1, "quarter shift");
        end
        $display("test parallel done");
        // serial: first load pops the word, second shifts it out
        axi_wr(CTRL_OFS, 32'h0000_0003, rsp);
        @(posedge clk);
        push(28'hc00_0000);
        phase_valid        <= 1'b0;
        phase_accum_enable <= 1'b1;
        @(posedge clk);
        phase_accum_enable <= 1'b0;
        repeat (18) @(posedge clk);
        phase_accum_enable <= 1'b1;
        @(posedge clk);
        phase_accum_enable <= 1'b0;
        c1 = fmt(amp[3], 1'b1);
        // twenty cycles: sixteen bits, then the fill values
        for (int k = 0; k < 20; k++)
        begin
            #1;
            check(sine_out, {(k < 16) ? c1[15 - k] : 1'b0, 14'h0000, (k < 16) ? c1[k] : c1[15]}, "serial sine");
            check(cosine_out, 16'h0000, "serial cosine");
            check(32'(converter_word_strobe), 32'(k == 0), "strobe");
            @(posedge clk);
        end
        check(sine_word, c1, "converter sine");
        check(cosine_word, 16'h0000, "converter cosine");
        $display("test serial done");
        // test view: fill until refused, then drain on enable
        axi_wr(CTRL_OFS, 32'h0000_0007, rsp);
        @(posedge clk);
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            q.push_back(28'($random(seed)));
            push(q[i]);
        end
        phase_valid <= 1'b0;
        #1;
        check(32'(phase_ready), 32'h0, "full buffer ready");
        axi_rd(STATUS_OFS, rd, rsp);
        check(rd, 32'h0000_1002, "status full");
        @(posedge clk);
        phase_accum_enable <= 1'b1;
        for (int i = 0; i < 18; i++)
        begin
            @(posedge clk);
            if (i == 15)
                phase_accum_enable <= 1'b0;
            #1;
            if (i >= 1 && i <= 16)
                check({sine_out, cosine_out}, {q[i - 1], 4'h0}, "phase view");
        end
        axi_rd(STATUS_OFS, rd, rsp);
        check(rd, 32'h0000_0001, "status empty");
        $display("test phase view done");
        end_of_test;
    end
endmodule // test_quad_amp_out

// ---- rtl/nco_out_pkg.sv ----
package nco_out_pkg;

    // ****************************************
    // widths and counts
    // ****************************************
    localparam int PHASE_W    = 28;            // phase word from the control section
    localparam int ADDR_W     = 20;            // lookup address taken from the top of the phase
    localparam int AMP_W      = 16;            // sine and cosine word width
    localparam int SER_BITS   = 16;            // bits per serial word
    localparam int FIFO_DEPTH = 16;            // words buffered ahead of the lookup

    // ****************************************
    // lookup constants
    // ****************************************
    localparam logic [18:0] QUARTER_TURN = 19'h4_0000; // one quarter cycle, fraction of 2^18
    localparam logic [19:0] THREE_QUART  = 20'hC_0000; // three in the same fixed point
    localparam logic [15:0] AMP_FULL     = 16'h7FFF;   // symmetric full scale

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [3:0] CTRL_OFS   = 4'h0;  // control bits, read and write
    localparam logic [3:0] STATUS_OFS = 4'h4;  // buffer state, read only
    localparam logic [3:0] SAMPLE_OFS = 4'h8;  // last amplitude pair, read only
    localparam int CTRL_OBIN_BIT = 0;          // offset_binary_select_n
    localparam int CTRL_SER_BIT  = 1;          // serial_output_select
    localparam int CTRL_TEST_BIT = 2;          // test mode
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic test_mode;                       // expose phase on the pins in serial mode
        logic serial_output_select;            // serial instead of parallel
        logic offset_binary_select_n;          // low selects offset binary
    } ctrl_s;

    typedef struct packed {
        logic [AMP_W-1:0] cosine;
        logic [AMP_W-1:0] sine;
    } amp_s;

    // two's complement after reset, parallel, no test
    localparam ctrl_s CTRL_RESET = '{test_mode: 1'b0, serial_output_select: 1'b0,
                                     offset_binary_select_n: 1'b1};

endpackage

// ---- rtl/quad_amp_out.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - take a 28-bit phase word as input
// - upper 20 bits address 16-bit sine, cosine
// - address linear over one cycle, zero is zero
// - two's complement output by default
// - symmetric amplitudes span 8001H to 7FFFH
// - offset binary select inverts both MSBs
// - serial select switches to serial output
// - enable loads shifters, otherwise shift each clock
// - MSB-first stream on bit 15
// - LSB-first stream on bit 0
// - MSB-first stream fills with zeros
// - LSB-first stream repeats the sign bit
// - strobe marks first bit of loaded word
// - test plus serial shows 28 phase bits
// - phase top word on sine, rest cosine
module quad_amp_out
    import nco_out_pkg::*;
#(
    parameter int DEPTH = nco_out_pkg::FIFO_DEPTH
) (
    input  wire logic                                clk,
    input  wire logic                                sys_rst,
    input  wire logic [nco_out_pkg::PHASE_W-1:0]     phase_word,
    input  wire logic                                phase_valid,
    output logic                                     phase_ready,
    input  wire logic                                phase_accum_enable,
    output logic [nco_out_pkg::AMP_W-1:0]            sine_out,
    output logic [nco_out_pkg::AMP_W-1:0]            cosine_out,
    output logic                                     converter_word_strobe,
    input  wire logic [3:0]                          s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    input  wire logic [3:0]                          s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    output logic [31:0]                              s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready
);
    import nco_out_pkg::*;

    localparam int LW = $clog2(DEPTH + 1);

    // ****************************************
    // amplitude lookup
    // ****************************************
    // quarter wave by a cubic, folded by quadrant; no rom, so the
    // spur level is far worse than a table, traded for area
    function automatic logic [AMP_W-1:0] amp_of(input logic [ADDR_W-1:0] a);
        logic [18:0] u;
        logic [37:0] u2;
        logic [19:0] diff;
        logic [38:0] prod;
        logic [35:0] mag;
        u    = a[18] ? (QUARTER_TURN - {1'b0, a[17:0]}) : {1'b0, a[17:0]};
        u2   = u * u;
        diff = THREE_QUART - u2[37:18];
        prod = u * diff;
        mag  = prod[38:19] * AMP_FULL;
        // negative half: never reaches 8000H since magnitude tops at 7FFFH
        amp_of = a[19] ? (AMP_W'(0) - mag[33:18]) : mag[33:18];
    endfunction

    // ****************************************
    // signals
    // ****************************************
    ctrl_s            ctrl_q;                  // software control bits
    logic [PHASE_W-1:0] fifo_data;             // head of buffer
    logic             fifo_valid;
    logic             fifo_take;               // drain side ready
    logic [LW-1:0]    fifo_level;
    logic [PHASE_W-1:0] phase_q;               // phase entering the lookup
    amp_s             amp;                     // lookup result, two's complement
    amp_s             fmt;                     // after format selection
    amp_s             last_q;                  // formatted lookup pair, registered every clock, for software
    logic             ser;
    logic             load;                    // shifters take a new word
    logic [AMP_W-1:0] msb_sin_q, msb_cos_q;    // MSB-first shifters
    logic [AMP_W-1:0] lsb_sin_q, lsb_cos_q;    // LSB-first shifters
    logic [AMP_W-1:0] msb_sin_d, msb_cos_d;
    logic [AMP_W-1:0] lsb_sin_d, lsb_cos_d;
    logic [AMP_W-1:0] sine_q, cosine_q;        // output flops
    logic             strobe_q;

    // ****************************************
    // input buffer
    // ****************************************
    // parallel drains every clock; serial drains only on a load, so a
    // slow serial cadence backs up into phase_ready
    assign ser       = ctrl_q.serial_output_select;
    assign fifo_take = ser ? phase_accum_enable : 1'b1;

    word_fifo #(
        .WIDTH (PHASE_W),
        .DEPTH (DEPTH)
    ) u_buf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_data   (phase_word),
        .in_valid  (phase_valid),
        .in_ready  (phase_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take),
        .level     (fifo_level)
    );

    // phase holder, keeps last word when buffer runs dry
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            phase_q <= '0;
        else if (fifo_valid && fifo_take)
            phase_q <= fifo_data;
    end

    // ****************************************
    // lookup and format
    // ****************************************
    // cosine is sine a quarter turn ahead
    always_comb
    begin
        amp.sine   = amp_of(phase_q[PHASE_W-1 -: ADDR_W]);
        amp.cosine = amp_of(phase_q[PHASE_W-1 -: ADDR_W] + ADDR_W'(QUARTER_TURN));
        fmt        = amp;
        if (!ctrl_q.offset_binary_select_n)
        begin
            fmt.sine[AMP_W-1]   = ~amp.sine[AMP_W-1];
            fmt.cosine[AMP_W-1] = ~amp.cosine[AMP_W-1];
        end
    end

    // ****************************************
    // serial shifters
    // ****************************************
    assign load = ser && phase_accum_enable;

    // next values: load a word, else shift one bit
    always_comb
    begin
        if (load)
        begin
            msb_sin_d = fmt.sine;
            msb_cos_d = fmt.cosine;
            lsb_sin_d = fmt.sine;
            lsb_cos_d = fmt.cosine;
        end
        else
        begin
            msb_sin_d = {msb_sin_q[AMP_W-2:0], 1'b0};
            msb_cos_d = {msb_cos_q[AMP_W-2:0], 1'b0};
            lsb_sin_d = {lsb_sin_q[AMP_W-1], lsb_sin_q[AMP_W-1:1]};
            lsb_cos_d = {lsb_cos_q[AMP_W-1], lsb_cos_q[AMP_W-1:1]};
        end
    end

    // shifter state
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            msb_sin_q <= '0;
            msb_cos_q <= '0;
            lsb_sin_q <= '0;
            lsb_cos_q <= '0;
        end
        else
        begin
            msb_sin_q <= msb_sin_d;
            msb_cos_q <= msb_cos_d;
            lsb_sin_q <= lsb_sin_d;
            lsb_cos_q <= lsb_cos_d;
        end
    end

    // ****************************************
    // output pins
    // ****************************************
    // outputs are fed from next-state values so a loaded word's first
    // bit shows at the same edge the strobe rises
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sine_q   <= '0;
            cosine_q <= '0;
        end
        else if (ser && ctrl_q.test_mode)
        begin
            sine_q   <= phase_q[PHASE_W-1 -: AMP_W];
            cosine_q <= {phase_q[PHASE_W-AMP_W-1:0], 4'h0};
        end
        else if (ser)
        begin
            // unused middle pins held low
            sine_q   <= {msb_sin_d[AMP_W-1], 14'h0, lsb_sin_d[0]};
            cosine_q <= {msb_cos_d[AMP_W-1], 14'h0, lsb_cos_d[0]};
        end
        else
        begin
            sine_q   <= fmt.sine;
            cosine_q <= fmt.cosine;
        end
    end

    // strobe: one clock, when the first bit of a fresh word is out
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            strobe_q <= 1'b0;
        else
            strobe_q <= load;
    end

    assign sine_out              = sine_q;
    assign cosine_out            = cosine_q;
    assign converter_word_strobe = strobe_q;

    // snapshot for software reads
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            last_q <= '0;
        else
            last_q <= fmt;
    end

    // ****************************************
    // register slave
    // ****************************************
    logic        aw_held_q, w_held_q;          // address and data captured
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // write path: address and data in either order, answer after both
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            ctrl_q    <= CTRL_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (aw_held_q && w_held_q && !bvalid_q)
            begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                // status words are read only; only control is writable
                if (awaddr_q == CTRL_OFS)
                begin
                    bresp_q <= RESP_OKAY;
                    if (wstrb_q[0])
                        ctrl_q <= ctrl_s'(wdata_q[2:0]);
                end
                else
                    bresp_q <= RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // read path: answer one clock after the address is taken
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            unique case (s_axi_araddr)
                CTRL_OFS:   rdata_q <= {29'h0, ctrl_q};
                STATUS_OFS: rdata_q <= {16'h0, 8'(fifo_level), 6'h0, fifo_valid, phase_ready};
                SAMPLE_OFS: rdata_q <= last_q;
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // ****************************************
    // checks
    // ****************************************
    sequence load_s;
        ser && phase_accum_enable;
    endsequence

    sequence shift_s;
        !phase_accum_enable;
    endsequence

    strobe_after_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        load_s |=> converter_word_strobe)
        else $error("strobe missing after load");

    strobe_has_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
        converter_word_strobe |-> $past(load))
        else $error("strobe without load");

    msb_zero_fill_a: assert property (@(posedge clk) disable iff (sys_rst)
        shift_s |=> (msb_sin_q[0] == 1'b0) && (msb_sin_q[15:1] == $past(msb_sin_q[14:0])))
        else $error("msb stream did not shift in zero");

    lsb_sign_fill_a: assert property (@(posedge clk) disable iff (sys_rst)
        shift_s |=> (lsb_cos_q[15] == $past(lsb_cos_q[15])) && (lsb_cos_q[14:0] == $past(lsb_cos_q[15:1])))
        else $error("lsb stream did not repeat sign");

    serial_msb_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ser && !ctrl_q.test_mode) ##0 shift_s |=> sine_out[15] == $past(msb_sin_q[14]))
        else $error("serial msb pin wrong");

    sym_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        $past(!ser && ctrl_q.offset_binary_select_n) |-> sine_out != 16'h8000 && cosine_out != 16'h8000)
        else $error("two's complement output hit 8000H");

    offset_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        $past(!ser && !ctrl_q.offset_binary_select_n) |-> sine_out != 16'h0000 && cosine_out != 16'h0000)
        else $error("offset binary output hit zero");

    test_phase_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ser && ctrl_q.test_mode) |=> sine_out == $past(phase_q[27:12]) && cosine_out[3:0] == 4'h0)
        else $error("test mode phase mapping wrong");

    zero_angle_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!ser && ctrl_q.offset_binary_select_n && phase_q[27:8] == 20'h0_0000)
        |=> sine_out == 16'h0000 && cosine_out == 16'h7FFF)
        else $error("zero address not zero angle");
endmodule // quad_amp_out

// ---- rtl/word_fifo.sv ----
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];           // flop storage
    logic [PW-1:0]    wr_q;                    // write index
    logic [PW-1:0]    rd_q;                    // read index
    logic [CW-1:0]    cnt_q;                   // words held
    logic             push;
    logic             pop;

    // honest flags straight from the count
    assign in_ready  = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage, no reset needed on the data
    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end
endmodule // word_fifo
